// [common/sfs_pkg.sv]
/*
 package for the quad switch fault supervisor: channel count, timing constants,
 per-channel sensor bundle, channel state encoding and the supply comparator bundle.
 assumes analog comparators outside present thresholds as synchronous levels.
*/
package sfs_pkg;
	localparam int SFS_CHANNELS = 4;
	// retry interval, documented as a per-channel internal period
	localparam int SFS_RETRY_US = 100;
	localparam int SFS_CLK_MHZ = 125;
	localparam int SFS_RETRY_CYCLES = SFS_RETRY_US * SFS_CLK_MHZ;
	localparam int SFS_CNT_W = 24;

	// per-channel sensor bundle from analog front end
	typedef struct packed {
		logic absOverTemp;     // fet temperature above absolute_temp_threshold
		logic absBelowHyst;    // fet temperature below trip minus temp_hysteresis
		logic relOverTemp;     // fet minus controller above relative_temp_threshold
		logic currentRegActive; // current limit regulating
		logic outAboveWirebreak; // output above offstate_wirebreak_threshold
	} sfs_sense_t;

	// supply comparator bundle
	typedef struct packed {
		logic mainBelowFalling; // main supply at or below main_supply_falling_threshold
		logic mainAboveRising;  // main supply above main_supply_rising_threshold
		logic mainAboveLockout; // main supply still above its lockout level
		logic logicBelowFalling; // logic_supply_lockout falling trip
		logic logicAboveRising;  // logic_supply_lockout rising release
	} sfs_supply_t;

	typedef enum logic [2:0] {
		SFS_CH_OK = 3'b001,
		SFS_CH_FAULT = 3'b010,
		SFS_CH_HOLD = 3'b100
	} sfs_ch_state_t;
endpackage

// [hdl/sfs_channel.sv]
/*
 one switch channel: thermal fault latching, retry timer, latch mode, off-state
 diagnostics and fault flag. assumes sense levels synchronous to clk.
*/
`timescale 1ns/10ps
module sfs_channel import sfs_pkg::*; #(
	parameter int RETRY_CYCLES = SFS_RETRY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// controls
	input wire logic channelEnableIn,
	input wire logic latchMode,
	input wire logic offstateDiagEnable,
	input wire logic outputsPermit,
	input wire sfs_sense_t sense,
	// results
	output logic channelOutput,
	output logic faultFlagLow,
	output logic tripped
);
	typedef struct packed {
		sfs_ch_state_t state;
		logic absFault;
		logic relFault;
		logic [SFS_CNT_W-1:0] retryCnt;
		logic enPrev;
		logic latchPrev;
		logic toggleSeen;
		logic on;
		logic flagLow;
	} sfs_ch_st_t;

	sfs_ch_st_t st_ff, nxt_st;
	logic thermTrip, retryDone, toggle, diagFault;

	always_comb begin
		thermTrip = sense.absOverTemp || sense.relOverTemp;
		retryDone = st_ff.retryCnt == '0;
		toggle = (channelEnableIn != st_ff.enPrev) || (latchMode != st_ff.latchPrev);
		// off-state short or open load, only with diagnostics on
		diagFault = offstateDiagEnable && !channelEnableIn && sense.outAboveWirebreak;
		nxt_st = st_ff;
		nxt_st.enPrev = channelEnableIn;
		nxt_st.latchPrev = latchMode;
		if (!retryDone)
			nxt_st.retryCnt = st_ff.retryCnt - 1'b1;
		// absolute fault clears only past hysteresis
		if (sense.absOverTemp)
			nxt_st.absFault = 1'b1;
		else if (sense.absBelowHyst)
			nxt_st.absFault = 1'b0;
		// relative fault clears when the retry time is spent
		if (sense.relOverTemp)
			nxt_st.relFault = 1'b1;
		else if (retryDone)
			nxt_st.relFault = 1'b0;
		case (st_ff.state)
			SFS_CH_OK: begin
				if (thermTrip) begin
					nxt_st.state = SFS_CH_FAULT;
					// own timer, started at detection
					nxt_st.retryCnt = SFS_CNT_W'(RETRY_CYCLES - 1);
					nxt_st.toggleSeen = 1'b0;
				end
			end
			SFS_CH_FAULT: begin
				// toggles inside the retry interval are ignored
				if (retryDone && !nxt_st.absFault && !nxt_st.relFault && !sense.currentRegActive) begin
					if (!latchMode)
						nxt_st.state = SFS_CH_OK;
					else
						nxt_st.state = SFS_CH_HOLD;
				end
			end
			SFS_CH_HOLD: begin
				if (thermTrip) begin
					nxt_st.state = SFS_CH_FAULT;
					nxt_st.retryCnt = SFS_CNT_W'(RETRY_CYCLES - 1);
				end else if (toggle || !latchMode)
					nxt_st.state = SFS_CH_OK;
			end
			default: nxt_st.state = SFS_CH_OK;
		endcase
		// switch on with enable when healthy and supplies fine
		nxt_st.on = channelEnableIn && outputsPermit && (nxt_st.state == SFS_CH_OK) && !thermTrip;
		// channel flag; supply issues never set it
		nxt_st.flagLow = outputsPermit && ((nxt_st.state != SFS_CH_OK) ||
			(channelEnableIn && sense.currentRegActive) || diagFault);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_ff <= '{state: SFS_CH_OK, default: '0};
		else if (clkEn)
			st_ff <= nxt_st;
	end

	assign channelOutput = st_ff.on;
	assign faultFlagLow = st_ff.flagLow;
	assign tripped = st_ff.state != SFS_CH_OK;

	property p_trip_off;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && thermTrip) |=> !channelOutput;
	endproperty
	a_trip_off: assert property (p_trip_off) else $error("channel on after thermal trip");

	sequence s_trip;
		clkEn && st_ff.state == SFS_CH_OK && thermTrip;
	endsequence
	property p_hold_retry;
		@(posedge clk) disable iff (!rst_n)
		s_trip |=> tripped [*8];
	endproperty
	a_hold_retry: assert property (p_hold_retry) else $error("fault left before retry");

	// diagnostics off and channel idle: the flag must stay released
	property p_diag_off;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && !offstateDiagEnable && !channelEnableIn && st_ff.state == SFS_CH_OK && !thermTrip)
			|=> !faultFlagLow;
	endproperty
	a_diag_off: assert property (p_diag_off) else $error("off-state flag with diagnostics off");
endmodule // sfs_channel

// [hdl/sfs_supply_mon.sv]
/*
 supply monitor: tracks main supply undervoltage and logic supply lockout with
 their hysteresis and produces an output-permit level and the supply fault flag.
 assumes comparator levels synchronous to clk.
*/
`timescale 1ns/10ps
module sfs_supply_mon import sfs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// comparators
	input wire sfs_supply_t supply,
	// status
	output logic outputsPermit,
	output logic supplyFaultOe_n
);
	typedef struct packed {
		logic mainOk;
		logic logicOk;
		logic flagLow;
	} sfs_sup_st_t;

	sfs_sup_st_t st_ff, nxt_st;

	// hysteresis on both supplies; both start not ok after reset
	always_comb begin
		nxt_st = st_ff;
		if (supply.mainBelowFalling)
			nxt_st.mainOk = 1'b0;
		else if (supply.mainAboveRising)
			nxt_st.mainOk = 1'b1;
		if (supply.logicBelowFalling)
			nxt_st.logicOk = 1'b0;
		else if (supply.logicAboveRising)
			nxt_st.logicOk = 1'b1;
		// flag only while main low but still above lockout
		nxt_st.flagLow = !nxt_st.mainOk && supply.mainAboveLockout;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			st_ff <= '0;
		else if (clkEn)
			st_ff <= nxt_st;
	end

	// both supplies must be up, whichever came first
	assign outputsPermit = st_ff.mainOk && st_ff.logicOk;
	// open-drain: enable low pulls the flag low
	assign supplyFaultOe_n = !st_ff.flagLow;

	property p_uv_off;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && supply.mainBelowFalling) |=> !outputsPermit;
	endproperty
	a_uv_off: assert property (p_uv_off) else $error("permit stays after undervoltage");

	property p_flag;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && supply.mainBelowFalling && supply.mainAboveLockout) |=> !supplyFaultOe_n;
	endproperty
	a_flag: assert property (p_flag) else $error("supply flag not pulled low");

	property p_recover;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && !supply.mainBelowFalling && supply.mainAboveRising) |=> supplyFaultOe_n;
	endproperty
	a_recover: assert property (p_recover) else $error("supply flag not released");

	property p_logic;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && supply.logicBelowFalling) |=> !outputsPermit;
	endproperty
	a_logic: assert property (p_logic) else $error("permit stays at logic lockout");
endmodule // sfs_supply_mon

// [hdl/sfs_switch_fault_supervisor.sv]
/*
 top of the quad switch fault supervisor: one supply monitor and four channels.
 assumes all inputs synchronous to clk; pins become output enables, low = pull.
*/
`timescale 1ns/10ps
// Behaviour
// - thermal fault when fet over absolute or relative threshold
// - thermal fault switches that channel off
// - absolute fault clears only after cooling by hysteresis
// - relative fault clears after retry interval
// - each channel senses, shuts down and reports independently
// - main undervoltage turns all outputs off
// - main undervoltage above lockout pulls supply fault flag low
// - main supply recovery re-enables outputs, releases supply flag
// - supply undervoltage never sets channel fault flags
// - logic supply lockout disables outputs until rising threshold
// - unpowered: flags and outputs released
// - outputs off until both supplies above rising thresholds
// - channel flag for thermal, current regulation, open load, short
// - diag enabled and channel off: report short and open load
// - diag disabled suppresses off-state detection
// - off-state fault when output above wire-break threshold
// - active channel switch on while enable high
// - auto-retry: recover after retry, faults gone, latch mode low
// - latch mode: stay off until toggle, toggles within retry ignored
module sfs_switch_fault_supervisor import sfs_pkg::*; #(
	parameter int CHANNELS = SFS_CHANNELS,
	parameter int RETRY_CYCLES = SFS_RETRY_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clkEn,
	// host controls
	input wire logic [CHANNELS-1:0] channel_enable_in,
	input wire logic offstate_diag_enable,
	input wire logic latchMode,
	// analog comparators
	input wire sfs_sense_t [CHANNELS-1:0] sense,
	input wire sfs_supply_t supply,
	// pins
	output logic [CHANNELS-1:0] channel_output,
	output logic [CHANNELS-1:0] channel_fault_flag_n_o,
	output logic [CHANNELS-1:0] channel_fault_flag_n_oe_n,
	output logic supply_fault_flag_n_o,
	output logic supply_fault_flag_n_oe_n,
	output logic [CHANNELS-1:0] channelTripped
);
	logic outputsPermit;
	logic [CHANNELS-1:0] flagLow;

	sfs_supply_mon u_supply (
		.clk(clk),
		.rst_n(rst_n),
		.clkEn(clkEn),
		.supply(supply),
		.outputsPermit(outputsPermit),
		.supplyFaultOe_n(supply_fault_flag_n_oe_n)
	);

	// one independent channel each
	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		sfs_channel #(.RETRY_CYCLES(RETRY_CYCLES)) u_ch (
			.clk(clk),
			.rst_n(rst_n),
			.clkEn(clkEn),
			.channelEnableIn(channel_enable_in[i]),
			.latchMode(latchMode),
			.offstateDiagEnable(offstate_diag_enable),
			.outputsPermit(outputsPermit),
			.sense(sense[i]),
			.channelOutput(channel_output[i]),
			.faultFlagLow(flagLow[i]),
			.tripped(channelTripped[i])
		);
	end

	// open drain: data always low, enable low while pulling
	assign channel_fault_flag_n_o = '0;
	assign channel_fault_flag_n_oe_n = ~flagLow;
	assign supply_fault_flag_n_o = 1'b0;

	property p_permit_out;
		@(posedge clk) disable iff (!rst_n)
		!outputsPermit |=> channel_output == '0; // permit is registered, outputs follow one edge later
	endproperty
	a_permit_out: assert property (p_permit_out) else $error("output on without supplies");

	property p_no_uv_flag;
		@(posedge clk) disable iff (!rst_n)
		!outputsPermit |=> channel_fault_flag_n_oe_n == '1;
	endproperty
	a_no_uv_flag: assert property (p_no_uv_flag) else $error("channel flag during undervoltage");

	property p_on_en;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && outputsPermit && channel_enable_in[0] && !channelTripped[0] && !sense[0].absOverTemp
			&& !sense[0].relOverTemp) ##1 (outputsPermit && !channelTripped[0]) |-> channel_output[0];
	endproperty
	a_on_en: assert property (p_on_en) else $error("enabled healthy channel off");

	property p_diag;
		@(posedge clk) disable iff (!rst_n)
		(clkEn && outputsPermit && !offstate_diag_enable && !channelTripped[0] && !channel_enable_in[0])
			|=> (channelTripped[0] || !outputsPermit || channel_fault_flag_n_oe_n[0]);
	endproperty
	a_diag: assert property (p_diag) else $error("off-state diag not suppressed");
endmodule // sfs_switch_fault_supervisor

// [tb/sfs_host_model.sv]
/*
 host side of the fault supervisor: the board pull-ups on the open-drain flags
 and the flag levels the host reads back.
 assumes the device drives each flag low only while its enable is low.
*/
`timescale 1ns/10ps
module sfs_host_model import sfs_pkg::*; (
	// open-drain pins from the device
	input wire logic [SFS_CHANNELS-1:0] chFlagO,
	input wire logic [SFS_CHANNELS-1:0] chFlagOe_n,
	input wire logic supFlagO,
	input wire logic supFlagOe_n,
	// levels seen by the host
	output logic [SFS_CHANNELS-1:0] chFlagSeen_n,
	output logic supFlagSeen_n
);
	// released lines float up to the pull-up level, never the last value
	assign chFlagSeen_n = chFlagO | chFlagOe_n;
	assign supFlagSeen_n = supFlagO | supFlagOe_n;
endmodule // sfs_host_model

// [tb/tb.sv]
/*
 bench for the quad switch fault supervisor: power-up, thermal, supply,
 diagnostic and latch scenarios. assumes a short retry count in simulation.
*/
`timescale 1ns/10ps
module tb import sfs_pkg::*; ;
	localparam int RC = 20;
	localparam sfs_supply_t SUP_OK = 5'h0D, SUP_MUV = 5'h15, SUP_MLO = 5'h11, SUP_LUV = 5'h0E, SUP_OFF = 5'h12;
	localparam sfs_sense_t S_COOL = 5'h08, S_REL = 5'h0C, S_ABS = 5'h10, S_WARM = 5'h00, S_CREG = 5'h0A;
	localparam sfs_sense_t S_WB = 5'h09;
	logic clk, rst_n, clkEn, diag, latch, supO, supOe_n, supFlag_n;
	logic [3:0] en, out, flO, flOe_n, trip, flag_n;
	sfs_sense_t [3:0] sense;
	sfs_supply_t supply;
	int failCount = 0;
	int nTests = 0;

	// device and host
	sfs_switch_fault_supervisor #(.RETRY_CYCLES(RC)) dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn),
		.channel_enable_in(en), .offstate_diag_enable(diag), .latchMode(latch), .sense(sense), .supply(supply),
		.channel_output(out), .channel_fault_flag_n_o(flO), .channel_fault_flag_n_oe_n(flOe_n),
		.supply_fault_flag_n_o(supO), .supply_fault_flag_n_oe_n(supOe_n), .channelTripped(trip));
	sfs_host_model host (.chFlagO(flO), .chFlagOe_n(flOe_n), .supFlagO(supO), .supFlagOe_n(supOe_n),
		.chFlagSeen_n(flag_n), .supFlagSeen_n(supFlag_n));

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		nTests++;
		if (got !== exp) begin
			failCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// wait n edges, then let their updates settle
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// bounded wait for outputs and flags; running out ends the run
	task automatic waitAll(input logic [3:0] expOut, input logic [3:0] expFlag, input int bound);
		int i;
		for (i = 0; i < bound && !(out === expOut && flag_n === expFlag); i++) begin
			cyc(1);
		end
		chk("outputs", expOut, out);
		chk("flags", expFlag, flag_n);
		if (out !== expOut || flag_n !== expFlag) begin
			summarize();
		end
	endtask

	// reset, power-up and scenario sequence
	initial begin
		rst_n = 1'b0;
		clkEn = 1'b1;
		en = 4'h0;
		diag = 1'b0;
		latch = 1'b0;
		supply = SUP_OFF;
		sense = {S_COOL, S_COOL, S_COOL, S_COOL};
		cyc(10);
		chk("outputs", 4'h0, out);
		chk("flags", 4'hF, flag_n);
		chk("supply flag", 4'h1, {3'h0, supFlag_n});
		@(posedge clk);
		rst_n <= 1'b1;
		supply <= SUP_MLO;
		cyc(3);
		chk("supply flag", 4'h1, {3'h0, supFlag_n});
		// enables stay low until the main supply is up
		@(posedge clk);
		supply <= SUP_OK;
		cyc(3);
		@(posedge clk);
		en <= 4'hF;
		waitAll(4'hF, 4'hF, 4);
		// relative faults on two channels a few cycles apart
		@(posedge clk);
		sense[0] <= S_REL;
		cyc(4);
		chk("outputs", 4'hE, out);
		chk("flags", 4'hE, flag_n);
		chk("tripped", 4'h1, trip);
		@(posedge clk);
		sense[0] <= S_COOL;
		sense[1] <= S_REL;
		cyc(3);
		@(posedge clk);
		sense[1] <= S_COOL;
		cyc(RC / 4);
		chk("outputs", 4'hC, out);
		waitAll(4'hD, 4'hD, 2 * RC);
		waitAll(4'hF, 4'hF, 2 * RC);
		// absolute fault holds until cooled past the hysteresis
		@(posedge clk);
		sense[2] <= S_ABS;
		cyc(3);
		@(posedge clk);
		sense[2] <= S_WARM;
		cyc(2 * RC);
		chk("outputs", 4'hB, out);
		@(posedge clk);
		sense[2] <= S_COOL;
		waitAll(4'hF, 4'hF, 2 * RC);
		// current regulation raises the flag
		@(posedge clk);
		sense[3] <= S_CREG;
		cyc(3);
		chk("flags", 4'h7, flag_n);
		@(posedge clk);
		sense[3] <= S_COOL;
		waitAll(4'hF, 4'hF, 2 * RC);
		// main undervoltage, then logic lockout, all channels enabled
		@(posedge clk);
		supply <= SUP_MUV;
		cyc(3);
		chk("outputs", 4'h0, out);
		chk("flags", 4'hF, flag_n);
		chk("supply flag", 4'h0, {3'h0, supFlag_n});
		@(posedge clk);
		supply <= SUP_OK;
		waitAll(4'hF, 4'hF, 4);
		chk("supply flag", 4'h1, {3'h0, supFlag_n});
		@(posedge clk);
		supply <= SUP_LUV;
		cyc(3);
		chk("outputs", 4'h0, out);
		@(posedge clk);
		supply <= SUP_OK;
		waitAll(4'hF, 4'hF, 4);
		// off-state detection on channel 0, diagnostics off then on
		@(posedge clk);
		en <= 4'hE;
		sense[0] <= S_WB;
		cyc(3);
		chk("flags", 4'hF, flag_n);
		@(posedge clk);
		diag <= 1'b1;
		cyc(3);
		chk("flags", 4'hE, flag_n);
		@(posedge clk);
		sense[0] <= S_COOL;
		en <= 4'hF;
		waitAll(4'hF, 4'hF, 2 * RC);
		// latched fault ignores a toggle inside the retry interval
		@(posedge clk);
		latch <= 1'b1;
		sense[1] <= S_REL;
		cyc(2);
		@(posedge clk);
		sense[1] <= S_COOL;
		en[1] <= 1'b0;
		cyc(1);
		@(posedge clk);
		en[1] <= 1'b1;
		cyc(2 * RC);
		chk("outputs", 4'hD, out);
		chk("flags", 4'hD, flag_n);
		@(posedge clk);
		en[1] <= 1'b0;
		cyc(1);
		@(posedge clk);
		en[1] <= 1'b1;
		waitAll(4'hF, 4'hF, 4);
		// clock enable low freezes state: enables dropped meanwhile take effect only after release
		@(posedge clk);
		clkEn <= 1'b0;
		en <= 4'h0;
		cyc(3);
		chk("frozen outputs", 4'hF, out);
		chk("frozen flags", 4'hF, flag_n);
		@(posedge clk);
		clkEn <= 1'b1;
		waitAll(4'h0, 4'hF, 4);
		summarize();
	end
endmodule // tb
